// >>> design/lpmrr_defs.svh
// Timing and field constants for the LPDDR4 mode-register-read link.
// Assumes the includer runs on a 20 MHz system clock.
`ifndef LPMRR_DEFS_SVH
`define LPMRR_DEFS_SVH
`define LPMRR_CLK_NS        50
`define LPMRR_CMD_MRR       3'h1
`define LPMRR_CMD_MRW       3'h2
`define LPMRR_CMD_PRE       3'h3
`define LPMRR_CMD_ZQS       3'h4
`define LPMRR_CMD_RD        3'h5
`define LPMRR_CMD_WR        3'h6
`define LPMRR_CMD_DES       3'h0
`define LPMRR_BL            16
`define LPMRR_MR_RD_DBI     6'h03
`define LPMRR_MR_POST       6'h01
`define LPMRR_DBI_BIT       6
`define LPMRR_POST_BIT      7
`define LPMRR_RDY_EXTRA     2
`define LPMRR_STOP_EXTRA    4
`define LPMRR_DATA_UI       4
`endif

// >>> design/lpmrr_pkg.sv
// Shared types for both ends of the mode-register-read link.
// Assumes lpmrr_defs.svh holds the numbers.
package lpmrr_pkg;
  typedef enum logic [1:0] {
    LPMRR_ACT  = 2'b00,
    LPMRR_PD   = 2'b01,
    LPMRR_XIT  = 2'b10,
    LPMRR_BURST = 2'b11
  } lpmrr_state_t;
endpackage : lpmrr_pkg

// >>> design/lpmrr_if.sv
// Link between controller and device: command bus plus read data.
// Assumes both ends share sys_clk.
`timescale 1ns/1ps
interface lpmrr_if;
  logic       cke;
  logic       csLo;
  logic       clkRun;
  logic [2:0] cmd;
  logic [5:0] addr;
  logic [7:0] wdata;
  logic [7:0] dq;
  logic       dqOe;
  logic       dqs;
  logic       dbi;
  modport dev  (input cke, csLo, clkRun, cmd, addr, wdata,
                output dq, dqOe, dqs, dbi);
  modport ctrl (output cke, csLo, clkRun, cmd, addr, wdata,
                input dq, dqOe, dqs, dbi);
endinterface : lpmrr_if

// >>> design/lpmrr_dev.sv
// Device end: power-down, clock stop, ZQ and mode register read.
// Assumes the controller keeps its own timing; inputs synchronous.
// Function
// - CKE low enters power-down, high exits
// - Precharge needs tCMDCKE before power-down
// - Hold CKE through MRR burst
// - MRW needs tMRWCKEL before power-down
// - ZQ calibration continues into power-down
// - CKE-low frequency change preconditions
// - Keep clock tCKELCK, stable tCKCKEH
// - Stopped clock ignored in power-down
// - CKE-high frequency change preconditions
// - Ready after 2 tCK plus tXP
// - CKE-high clock stop holds CS low
// - Four extra cycles before clock stop
// - Auto precharge needs four extra cycles
// - Refresh and ZQ need four extra cycles
// - Six-bit address picks one of 64
// - OP bits on DQ first four UIs; code drives them on UIs two to five, first UI carries zero
// - MRR burst sixteen, DQS toggles
// - Read DBI from MR3 bit six
// - MRR pre/postamble as normal read
// - Only deselect during tMRR
// - Spacing READ/WRITE to MRR
// - tWTR starts after last DQS edge
// - tXP plus tMRRI before MRR
`timescale 1ns/1ps
`include "lpmrr_defs.svh"
module lpmrr_dev import lpmrr_pkg::*; #(
  parameter int RL     = 6,
  parameter int TXP    = 2,
  parameter int TZQCAL = 20
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // Link
  lpmrr_if.dev      link,
  // Status
  output logic      ready_r,
  output logic      zqBusy_r
);
  // ************************
  // Mode register array
  // ************************
  logic [7:0]   modeReg_r [64];
  lpmrr_state_t state_r;
  logic [7:0]   cnt_r;
  logic [5:0]   rdAddr_r;
  logic [7:0]   lat_r;
  logic         pend_r;
  logic [7:0]   zqCnt_r;
  logic [7:0]   dq_r;
  logic         oe_r;
  logic         dqs_r;
  logic         dbi_r;
  logic [7:0]   opByte;
  logic         inv;

  // Stopped clock freezes all command decode
  wire clkOk = link.clkRun;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 64; i++) modeReg_r[i] <= 8'h00;
    // Writes only land while awake and idle
    end else if (clkOk && link.cke && state_r == LPMRR_ACT &&
                 link.cmd == `LPMRR_CMD_MRW) begin
      modeReg_r[link.addr] <= link.wdata;
    end
  end

  // ************************
  // Power state
  // ************************
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_r <= LPMRR_ACT;
      cnt_r   <= 8'h00;
      ready_r <= 1'b0;
    // Power-down takes priority over any command
    end else if (!link.cke) begin
      state_r <= LPMRR_PD;
      ready_r <= 1'b0;
      cnt_r   <= 8'h00;
    end else if (!clkOk) begin
      ready_r <= 1'b0;
      cnt_r   <= 8'h00;
    end else begin
      case (state_r)
        LPMRR_PD: begin
          state_r <= LPMRR_XIT;
          cnt_r   <= 8'h00;
        end
        // Exit latency plus two cycles before ready
        LPMRR_XIT: begin
          cnt_r <= cnt_r + 8'h01;
          if (cnt_r >= 8'(TXP + `LPMRR_RDY_EXTRA - 1)) begin
            state_r <= LPMRR_ACT;
            ready_r <= 1'b1;
          end
        end
        LPMRR_ACT: begin
          ready_r <= (cnt_r >= 8'(`LPMRR_RDY_EXTRA + TXP - 1));
          if (cnt_r < 8'hFF) cnt_r <= cnt_r + 8'h01;
          if (link.cmd == `LPMRR_CMD_MRR) begin
            state_r <= LPMRR_BURST;
          end
        end
        // Further commands ignored until burst ends
        LPMRR_BURST: begin
          if (oe_r && lat_r == 8'(`LPMRR_BL - 1)) state_r <= LPMRR_ACT;
        end
        default: state_r <= LPMRR_ACT;
      endcase
    end
  end

  // ************************
  // ZQ calibration
  // ************************
  // Counts on sys_clk so it keeps going through power-down
  // A new start wins over the running count
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      zqCnt_r  <= 8'h00;
      zqBusy_r <= 1'b0;
    end else if (clkOk && link.cke && state_r == LPMRR_ACT &&
                 link.cmd == `LPMRR_CMD_ZQS) begin
      zqCnt_r  <= 8'(TZQCAL);
      zqBusy_r <= 1'b1;
    end else if (zqCnt_r != 8'h00) begin
      zqCnt_r  <= zqCnt_r - 8'h01;
      zqBusy_r <= (zqCnt_r != 8'h01);
    end
  end

  // ************************
  // MRR burst
  // ************************
  assign opByte = modeReg_r[rdAddr_r];
  assign inv = modeReg_r[`LPMRR_MR_RD_DBI][`LPMRR_DBI_BIT] &&
               ($countones(opByte) > 4);

  // ************************
  // Lane inversion
  // ************************
  // One bit per lane; the byte flips as a whole when DBI fires
  logic [7:0] laneOut;
  genvar gb;
  generate
    for (gb = 0; gb < 8; gb++) begin : g_lane
      assign laneOut[gb] = opByte[gb] ^ inv;
    end
  endgenerate

  // ************************
  // Burst sequencing
  // ************************
  // Latency count, then sixteen UIs with strobe
  // One UI per clock keeps the link single-rate, at half the speed
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pend_r   <= 1'b0;
      rdAddr_r <= 6'h00;
      lat_r    <= 8'h00;
      oe_r     <= 1'b0;
      dqs_r    <= 1'b0;
      dq_r     <= 8'h00;
      dbi_r    <= 1'b0;
    end else if (state_r == LPMRR_ACT && clkOk && link.cke &&
                 link.cmd == `LPMRR_CMD_MRR) begin
      pend_r   <= 1'b1;
      rdAddr_r <= link.addr;
      lat_r    <= 8'h00;
    end else if (pend_r && !oe_r) begin
      lat_r <= lat_r + 8'h01;
      if (lat_r == 8'(RL - 1)) begin
        oe_r  <= 1'b1;
        lat_r <= 8'h00;
      end
    end else if (oe_r) begin
      dqs_r <= ~dqs_r;
      if (lat_r < 8'(`LPMRR_DATA_UI)) begin
        dq_r  <= laneOut;
        dbi_r <= inv;
      end else begin
        // Later UIs carry zero; the far end must not use them
        dq_r  <= 8'h00;
        dbi_r <= 1'b0;
      end
      lat_r <= lat_r + 8'h01;
      if (lat_r == 8'(`LPMRR_BL - 1)) begin
        oe_r   <= 1'b0;
        pend_r <= 1'b0;
        dqs_r  <= 1'b0;
      end
    end
  end

  // ************************
  // Link drive
  // ************************
  assign link.dq   = dq_r;
  assign link.dqOe = oe_r;
  assign link.dqs  = dqs_r;
  assign link.dbi  = dbi_r;
endmodule : lpmrr_dev

// >>> design/lpmrr_ctrl.sv
// Controller end: issues MRR/MRW/ZQ/PD with required spacing.
// Assumes user requests one at a time, pulse while busy_r low.
`timescale 1ns/1ps
`include "lpmrr_defs.svh"
module lpmrr_ctrl import lpmrr_pkg::*; #(
  parameter int RL       = 6,
  parameter int TXP      = 2,
  parameter int TMRRI    = 3,
  parameter int TCMDCKE  = 2,
  parameter int TMRWCKEL = 3,
  parameter int TZQCKE   = 2,
  parameter int TCKELCK  = 2
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // Link
  lpmrr_if.ctrl           link,
  // User requests
  input  wire logic [2:0] reqCmd,
  input  wire logic [5:0] reqAddr,
  input  wire logic [7:0] reqData,
  input  wire logic       reqValid,
  input  wire logic       pdReq,
  input  wire logic       stopReq,
  // Results
  output logic            busy_r,
  output logic [7:0]      rdData_r,
  output logic            rdValid_r
);
  logic [7:0] wait_r;
  logic [7:0] ui_r;
  logic       cke_r;
  logic       run_r;
  logic [2:0] cmd_r;
  logic [5:0] addr_r;
  logic [7:0] wd_r;

  // ************************
  // Command issue
  // ************************
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wait_r <= 8'h00;
      busy_r <= 1'b0;
      cke_r  <= 1'b1;
      run_r  <= 1'b1;
      cmd_r  <= `LPMRR_CMD_DES;
      addr_r <= 6'h00;
      wd_r   <= 8'h00;
    end else begin
      cmd_r <= `LPMRR_CMD_DES;
      if (wait_r != 8'h00) begin
        wait_r <= wait_r - 8'h01;
        busy_r <= (wait_r != 8'h01);
      end else if (!cke_r) begin
        if (!pdReq) begin
          cke_r  <= 1'b1;
          wait_r <= 8'(TXP + TMRRI);
          busy_r <= 1'b1;
        end
      end else if (!run_r) begin
        if (!stopReq) begin
          run_r  <= 1'b1;
          wait_r <= 8'(`LPMRR_RDY_EXTRA + TXP);
          busy_r <= 1'b1;
        end
      end else if (pdReq) begin
        cke_r  <= 1'b0;
        wait_r <= 8'(TCKELCK);
        busy_r <= 1'b1;
      end else if (stopReq) begin
        run_r <= 1'b0;
      end else if (reqValid) begin
        cmd_r  <= reqCmd;
        addr_r <= reqAddr;
        wd_r   <= reqData;
        busy_r <= 1'b1;
        case (reqCmd)
          `LPMRR_CMD_MRR: wait_r <= 8'(RL + `LPMRR_BL + 2);
          `LPMRR_CMD_MRW: wait_r <= 8'(TMRWCKEL + `LPMRR_STOP_EXTRA);
          `LPMRR_CMD_PRE: wait_r <= 8'(TCMDCKE + `LPMRR_STOP_EXTRA);
          `LPMRR_CMD_ZQS: wait_r <= 8'(TZQCKE + `LPMRR_STOP_EXTRA);
          `LPMRR_CMD_RD:  wait_r <= 8'(`LPMRR_BL / 2);
          `LPMRR_CMD_WR:  wait_r <= 8'(RL + `LPMRR_BL / 2 + 2);
          default:        wait_r <= 8'h01;
        endcase
      end
    end
  end

  // ************************
  // Read capture
  // ************************
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ui_r      <= 8'h00;
      rdData_r  <= 8'h00;
      rdValid_r <= 1'b0;
    end else begin
      rdValid_r <= 1'b0;
      if (!link.dqOe) begin
        ui_r <= 8'h00;
      end else begin
        ui_r <= ui_r + 8'h01;
        if (ui_r == 8'h01) begin
          rdData_r  <= link.dbi ? ~link.dq : link.dq;
          rdValid_r <= 1'b1;
        end
      end
    end
  end

  assign link.cke    = cke_r;
  assign link.csLo   = 1'b1;
  assign link.clkRun = run_r;
  assign link.cmd    = cmd_r;
  assign link.addr   = addr_r;
  assign link.wdata  = wd_r;
endmodule : lpmrr_ctrl

// >>> bench/lpmrr_sva.sv
// Checker for the mode-register-read link between the two ends.
// Assumes the bench top instantiates it beside the interface.
`timescale 1ns/1ps
module lpmrr_sva #(
  parameter int RL = 6
) (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       rst_n,
  // Command side
  input wire logic       cke,
  input wire logic       csLo,
  input wire logic       clkRun,
  input wire logic [2:0] cmd,
  input wire logic [5:0] addr,
  input wire logic [7:0] wdata,
  // Read data side
  input wire logic [7:0] dq,
  input wire logic       dqOe,
  input wire logic       dqs,
  input wire logic       dbi
);
  localparam int RLD = RL + 1;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ************************
  // Link timing properties
  // ************************
  property p_burst16; $rose(dqOe) |-> ##15 dqOe ##1 !dqOe; endproperty
  a_burst16: assert property (p_burst16)
    else $error("read burst length wrong");
  property p_mrrLat;
    (cmd == 3'h1 && cke && clkRun && !dqOe) |-> ##[RLD:RLD] $rose(dqOe);
  endproperty
  a_mrrLat: assert property (p_mrrLat)
    else $error("read data late or early");
  property p_dqsTog; dqOe && $past(dqOe) |-> dqs != $past(dqs); endproperty
  a_dqsTog: assert property (p_dqsTog)
    else $error("strobe stalled in burst");
  property p_desOnly; cmd == 3'h1 |=> (cmd == 3'h0) [*8]; endproperty
  a_desOnly: assert property (p_desOnly)
    else $error("command inside read window");
  property p_ckeBurst; dqOe |-> cke; endproperty
  a_ckeBurst: assert property (p_ckeBurst)
    else $error("power-down during burst");
  property p_preCke; cmd == 3'h3 |-> cke [*2]; endproperty
  a_preCke: assert property (p_preCke)
    else $error("power-down too soon after precharge");
  property p_mrwCke; cmd == 3'h2 |-> cke [*3]; endproperty
  a_mrwCke: assert property (p_mrwCke)
    else $error("power-down too soon after write");
  property p_zqCke; cmd == 3'h4 |-> cke [*2]; endproperty
  a_zqCke: assert property (p_zqCke)
    else $error("power-down too soon after calibration");
  property p_exitWait; $rose(cke) |-> (cmd != 3'h1) [*5]; endproperty
  a_exitWait: assert property (p_exitWait)
    else $error("read too soon after exit");
  property p_ckeLowClk; $fell(cke) |-> clkRun [*2]; endproperty
  a_ckeLowClk: assert property (p_ckeLowClk)
    else $error("clock stopped too soon");
  property p_stopCs; !clkRun && cke |-> csLo; endproperty
  a_stopCs: assert property (p_stopCs)
    else $error("select not low while stopped");
  property p_stopGap; cmd != 3'h0 |-> clkRun [*5]; endproperty
  a_stopGap: assert property (p_stopGap)
    else $error("clock stopped too soon after command");
endmodule : lpmrr_sva

// >>> bench/tb_lpddr4_pd_clkstop_mrr_timing.sv
// Bench: both link ends back to back, random and corner reads.
// Assumes design files compiled first; 20 MHz clock.
`timescale 1ns/1ps
module tb_lpddr4_pd_clkstop_mrr_timing import lpmrr_pkg::*;;
  logic       sys_clk, rst_n, reqValid, pdReq, stopReq;
  logic [2:0] reqCmd;
  logic [5:0] reqAddr, a;
  logic [7:0] reqData, d, rdData_r;
  logic       busy_r, rdValid_r, ready_r, zqBusy_r;
  logic [7:0] mr [64];
  int         error_cnt, checked, cyc;
  lpmrr_if link ();
  lpmrr_dev i_lpmrr_dev (.sys_clk, .rst_n, .link(link), .ready_r,
    .zqBusy_r);
  lpmrr_ctrl i_lpmrr_ctrl (.sys_clk, .rst_n, .link(link), .reqCmd,
    .reqAddr, .reqData, .reqValid, .pdReq, .stopReq, .busy_r, .rdData_r,
    .rdValid_r);
  lpmrr_sva #(.RL(6)) i_lpmrr_sva (.sys_clk, .rst_n, .cke(link.cke),
    .csLo(link.csLo), .clkRun(link.clkRun), .cmd(link.cmd),
    .addr(link.addr), .wdata(link.wdata), .dq(link.dq),
    .dqOe(link.dqOe), .dqs(link.dqs), .dbi(link.dbi));
  initial begin
    sys_clk = 0;
    forever #25 sys_clk = ~sys_clk;
  end
  // Hang guard, well above the run length
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end
  task automatic chk(input logic [8:0] s, input logic [8:0] e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // Inversion expected on the wire when read DBI is on
  function automatic logic [8:0] onWire(input logic [7:0] x);
    return (mr[3][6] && $countones(x) > 4) ? {1'b1, ~x} : {1'b0, x};
  endfunction : onWire
  task automatic req(input logic [2:0] c, input logic [5:0] ad,
                     input logic [7:0] dt);
    for (int i = 0; i < 99 && busy_r !== 1'b0; i++) @(negedge sys_clk);
    reqCmd = c;
    reqAddr = ad;
    reqData = dt;
    reqValid = 1;
    @(negedge sys_clk);
    reqValid = 0;
    if (c == 3'h2) mr[ad] = dt;
  endtask : req
  task automatic mrr(input logic [5:0] ad);
    req(3'h1, ad, 8'h00);
    for (int i = 0; i < 40 && link.dqOe !== 1'b1; i++) @(negedge sys_clk);
    @(negedge sys_clk);
    chk({link.dbi, link.dq}, onWire(mr[ad]));
    for (int i = 0; i < 40 && rdValid_r !== 1'b1; i++) @(negedge sys_clk);
    chk(rdData_r, mr[ad]);
  endtask : mrr
  task automatic waitReady();
    for (int i = 0; i < 60 && ready_r !== 1'b1; i++) @(negedge sys_clk);
    chk(ready_r, 1'b1);
  endtask : waitReady
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim
  initial begin
    {rst_n, reqValid, pdReq, stopReq, reqCmd, reqAddr, reqData} = '0;
    foreach (mr[i]) mr[i] = 8'h00;
    void'($urandom(32'hAB22EC08));
    repeat (10) @(negedge sys_clk);
    rst_n = 1;
    waitReady();
    mrr(6'h3F);
    $display("test reset done");
    req(3'h2, 6'h03, 8'h40);
    req(3'h2, 6'h05, 8'hF8);
    mrr(6'h05);
    repeat (8) begin
      a = 6'($urandom);
      d = 8'($urandom);
      req(3'h2, a, d);
      mrr(a);
    end
    $display("test random reads done");
    for (int c = 3; c < 7; c++) begin
      req(3'(c), 6'h00, 8'h00);
      if (c == 4) begin
        @(negedge sys_clk);
        chk(zqBusy_r, 1'b1);
      end
      mrr(6'h05);
    end
    $display("test command spacing done");
    for (int i = 0; i < 99 && busy_r !== 1'b0; i++) @(negedge sys_clk);
    pdReq = 1;
    repeat (20) @(negedge sys_clk);
    chk(link.cke, 1'b0);
    pdReq = 0;
    // Let the exit edge raise busy before the next request
    @(negedge sys_clk);
    mrr(6'h05);
    $display("test power-down done");
    stopReq = 1;
    repeat (20) @(negedge sys_clk);
    chk({link.clkRun, link.csLo}, 2'b01);
    stopReq = 0;
    waitReady();
    mrr(6'h03);
    $display("test clock stop done");
    end_sim();
  end
endmodule : tb_lpddr4_pd_clkstop_mrr_timing
